// file: hdl/command_mode_diagnostics.sv
// Command-mode entry detector, command timeout and diagnostic parameters.
// Assumes the serial receiver, command parser and radio events share clock_i.
`timescale 1ns/100ps
module command_mode_diagnostics
  import cmd_diag_pkg::*;
#(
  parameter int unsigned    MS_CYCLES      = MS_TICK_CYCLES,
  parameter int unsigned    SCAN_CYCLES    = SCAN_UNIT_CYCLES,
  parameter int unsigned    CHANNELS       = 16,
  parameter logic [15:0]    FIRMWARE_VALUE = 16'h1234,   // Arbitrary value
  parameter logic [15:0]    HARDWARE_VALUE = 16'h5678    // Arbitrary value
) (
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  // Received serial bytes
  input  wire logic         rx_valid_i,
  input  wire logic [7:0]   rx_byte_i,
  output logic              data_valid_o,
  output logic [7:0]        data_byte_o,
  output logic              command_mode_o,
  // Parsed commands and answers
  input  wire logic         cmd_valid_i,
  input  wire cmd_req_s     cmd_req_i,
  output logic              rsp_valid_o,
  output cmd_rsp_s          rsp_o,
  output logic              reinit_o,
  output param_set_s        params_o,
  // Radio events
  input  wire logic         cca_fail_i,
  input  wire logic         retry_exhaust_i,
  input  wire logic         rssi_update_i,
  input  wire logic [7:0]   rssi_i,
  // Energy scan
  input  wire logic [7:0]   energy_i,
  output logic [7:0]        scan_channel_o,
  output logic              scan_busy_o,
  output logic              tx_valid_o,
  output logic [7:0]        tx_byte_o,
  input  wire logic         tx_ready_i
);

  typedef enum logic [3:0] {
    M_DATA = 4'b0001,
    M_SEQ  = 4'b0010,
    M_POST = 4'b0100,
    M_CMD  = 4'b1000
  } mode_e;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_DWELL = 4'b0010,
    S_VALUE = 4'b0100,
    S_CR    = 4'b1000
  } scan_e;

  mode_e             mode_q;
  scan_e             scan_q;
  param_set_s        active_q;
  param_set_s        queued_q;
  logic [31:0]       silence_pre_q;
  logic [15:0]       silence_ms_q;
  logic [31:0]       idle_pre_q;
  logic [23:0]       idle_ms_q;
  logic [1:0]        esc_seen_q;
  logic [7:0]        rssi_q;
  logic              rsp_valid_q;
  cmd_rsp_s          rsp_q;
  logic              reinit_q;
  logic              data_valid_q;
  logic [7:0]        data_byte_q;
  logic [38:0]       dwell_q;
  logic [7:0]        channel_q;
  logic [7:0]        peak_q;
  logic [7:0]        tx_byte_q;
  logic [15:0]       busy_count;
  logic [15:0]       retry_count;
  logic              cmd_take;
  logic              is_esc;
  logic              guard_met;
  logic              timed_out;
  logic              leave_cmd;
  logic              apply_cmd;
  logic              busy_clr;
  logic              retry_clr;
  logic              scan_start;
  logic              bad_write;
  logic [38:0]       dwell_len;

  // Commands only count while in command mode
  assign cmd_take   = cmd_valid_i && (mode_q == M_CMD);
  assign is_esc     = rx_byte_i == active_q.esc;
  assign guard_met  = silence_ms_q >= active_q.guard;
  assign timed_out  = idle_ms_q >= (24'(active_q.timeout) * 24'(TIMEOUT_UNIT_MS));
  assign leave_cmd  = cmd_take && cmd_req_i.code == CMD_LEAVE;
  assign apply_cmd  = cmd_take && cmd_req_i.code == CMD_APPLY;
  assign busy_clr   = cmd_take && cmd_req_i.write && cmd_req_i.code == CMD_CHANNEL_BUSY
                      && cmd_req_i.wdata == '0;
  assign retry_clr  = cmd_take && cmd_req_i.write && cmd_req_i.code == CMD_RETRY_EXHAUST
                      && cmd_req_i.wdata == '0;
  assign scan_start = cmd_take && cmd_req_i.code == CMD_ENERGY_SCAN && scan_q == S_IDLE;
  assign dwell_len  = 39'(SCAN_CYCLES) << active_q.exponent;

  // Writes outside the legal range or to fixed values are refused
  always_comb begin
    bad_write = 1'b0;
    if (cmd_req_i.write) begin
      case (cmd_req_i.code)
        CMD_CHANNEL_BUSY,
        CMD_RETRY_EXHAUST:   bad_write = cmd_req_i.wdata != '0;
        CMD_COMMAND_TIMEOUT: bad_write = cmd_req_i.wdata < TIMEOUT_MIN;
        CMD_GUARD_TIME:      bad_write = cmd_req_i.wdata < GUARD_MIN
                                         || cmd_req_i.wdata > GUARD_MAX;
        CMD_ESCAPE_CHAR:     bad_write = cmd_req_i.wdata[15:8] != '0;
        CMD_SCAN_EXPONENT:   bad_write = cmd_req_i.wdata > 16'(EXP_MAX);
        CMD_ENERGY_SCAN,
        CMD_LEAVE,
        CMD_APPLY:           bad_write = 1'b0;
        default:             bad_write = 1'b1;
      endcase
    end
  end

  // Silence timer, restarted by every received byte
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      silence_pre_q <= '0;
      silence_ms_q  <= '0;
    end else if (rx_valid_i) begin
      silence_pre_q <= '0;
      silence_ms_q  <= '0;
    end else if (silence_pre_q == MS_CYCLES - 1) begin
      silence_pre_q <= '0;
      if (silence_ms_q != COUNT_MAX) begin
        silence_ms_q <= silence_ms_q + 16'h0001;
      end
    end else begin
      silence_pre_q <= silence_pre_q + 32'h0000_0001;
    end
  end

  // Inactivity timer, restarted by entry and each valid command
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      idle_pre_q <= '0;
      idle_ms_q  <= '0;
    end else if (mode_q != M_CMD || cmd_take) begin
      idle_pre_q <= '0;
      idle_ms_q  <= '0;
    end else if (idle_pre_q == MS_CYCLES - 1) begin
      idle_pre_q <= '0;
      if (!timed_out) begin
        idle_ms_q <= idle_ms_q + 24'h00_0001;
      end
    end else begin
      idle_pre_q <= idle_pre_q + 32'h0000_0001;
    end
  end

  // Entry sequence detector and command-mode state
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mode_q     <= M_DATA;
      esc_seen_q <= '0;
    end else begin
      case (mode_q)
        M_DATA: begin
          if (rx_valid_i && is_esc && guard_met) begin
            mode_q     <= M_SEQ;
            esc_seen_q <= 2'h1;
          end
        end
        M_SEQ: begin
          if (rx_valid_i && !is_esc) begin
            mode_q <= M_DATA;
          end else if (rx_valid_i) begin
            esc_seen_q <= esc_seen_q + 2'h1;
            if (esc_seen_q + 2'h1 == ESC_COUNT) begin
              mode_q <= M_POST;
            end
          end
        end
        M_POST: begin
          if (rx_valid_i) begin
            mode_q <= M_DATA;
          end else if (guard_met) begin
            mode_q <= M_CMD;
          end
        end
        M_CMD: begin
          if (leave_cmd || timed_out) begin
            mode_q <= M_DATA;
          end
        end
        default: mode_q <= M_DATA;
      endcase
    end
  end

  // Bytes outside command mode pass on as ordinary data
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      data_valid_q <= 1'b0;
      data_byte_q  <= '0;
    end else begin
      data_valid_q <= rx_valid_i && mode_q != M_CMD;
      if (rx_valid_i) begin
        data_byte_q <= rx_byte_i;
      end
    end
  end

  // Queued parameter writes
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      queued_q <= PARAM_RESET;
    end else if (cmd_take && cmd_req_i.write && !bad_write) begin
      case (cmd_req_i.code)
        CMD_COMMAND_TIMEOUT: queued_q.timeout  <= cmd_req_i.wdata;
        CMD_GUARD_TIME:      queued_q.guard    <= cmd_req_i.wdata;
        CMD_ESCAPE_CHAR:     queued_q.esc      <= cmd_req_i.wdata[7:0];
        CMD_SCAN_EXPONENT:   queued_q.exponent <= cmd_req_i.wdata[2:0];
        default:             queued_q <= queued_q;
      endcase
    end
  end

  // Active parameters change only on apply or leave command
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      active_q <= PARAM_RESET;
      reinit_q <= 1'b0;
    end else begin
      reinit_q <= apply_cmd || leave_cmd;
      if (apply_cmd || leave_cmd) begin
        active_q <= queued_q;
      end
    end
  end

  // Signal level of last good packet
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rssi_q <= '0;
    end else if (rssi_update_i) begin
      rssi_q <= rssi_i;
    end
  end

  sat_counter #(
    .WIDTH   (WORD_W)
  ) u_busy_count (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .inc_i   (cca_fail_i),
    .clr_i   (busy_clr),
    .count_o (busy_count)
  );

  sat_counter #(
    .WIDTH   (WORD_W)
  ) u_retry_count (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .inc_i   (retry_exhaust_i),
    .clr_i   (retry_clr),
    .count_o (retry_count)
  );

  // Command answer, one cycle after the command
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= cmd_take;
      if (cmd_take) begin
        rsp_q.err <= bad_write || (cmd_req_i.code == CMD_ENERGY_SCAN && scan_q != S_IDLE);
        case (cmd_req_i.code)
          CMD_FIRMWARE_VERSION: rsp_q.rdata <= FIRMWARE_VALUE;
          CMD_HARDWARE_VERSION: rsp_q.rdata <= HARDWARE_VALUE;
          CMD_RSSI_LEVEL:       rsp_q.rdata <= {8'h00, rssi_q};
          CMD_CHANNEL_BUSY:     rsp_q.rdata <= busy_count;
          CMD_RETRY_EXHAUST:    rsp_q.rdata <= retry_count;
          CMD_COMMAND_TIMEOUT:  rsp_q.rdata <= queued_q.timeout;
          CMD_GUARD_TIME:       rsp_q.rdata <= queued_q.guard;
          CMD_ESCAPE_CHAR:      rsp_q.rdata <= {8'h00, queued_q.esc};
          CMD_SCAN_EXPONENT:    rsp_q.rdata <= {13'h0, queued_q.exponent};
          default:              rsp_q.rdata <= '0;
        endcase
      end
    end
  end

  // Energy scan over all channels
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      scan_q    <= S_IDLE;
      dwell_q   <= '0;
      channel_q <= '0;
      peak_q    <= '0;
      tx_byte_q <= '0;
    end else begin
      case (scan_q)
        S_IDLE: begin
          if (scan_start) begin
            scan_q    <= S_DWELL;
            dwell_q   <= '0;
            channel_q <= '0;
            peak_q    <= 8'hff;
          end
        end
        S_DWELL: begin
          // peak energy is the smallest magnitude
          if (energy_i < peak_q) begin
            peak_q <= energy_i;
          end
          if (dwell_q == dwell_len - 39'h1) begin
            scan_q    <= S_VALUE;
            tx_byte_q <= (energy_i < peak_q) ? energy_i : peak_q;
          end else begin
            dwell_q <= dwell_q + 39'h1;
          end
        end
        S_VALUE: begin
          if (tx_ready_i) begin
            scan_q    <= S_CR;
            tx_byte_q <= CR_BYTE;
          end
        end
        S_CR: begin
          if (tx_ready_i) begin
            dwell_q <= '0;
            peak_q  <= 8'hff;
            if (channel_q == 8'(CHANNELS - 1)) begin
              scan_q <= S_IDLE;
            end else begin
              scan_q    <= S_DWELL;
              channel_q <= channel_q + 8'h01;
            end
          end
        end
        default: scan_q <= S_IDLE;
      endcase
    end
  end

  // Output drive
  assign data_valid_o   = data_valid_q;
  assign data_byte_o    = data_byte_q;
  assign command_mode_o = mode_q == M_CMD;
  assign rsp_valid_o    = rsp_valid_q;
  assign rsp_o          = rsp_q;
  assign reinit_o       = reinit_q;
  assign params_o       = active_q;
  assign scan_channel_o = channel_q;
  assign scan_busy_o    = scan_q != S_IDLE;
  assign tx_valid_o     = scan_q == S_VALUE || scan_q == S_CR;
  assign tx_byte_o      = tx_byte_q;

endmodule

// file: hdl/sat_counter.sv
// Saturating event counter with clear.
// Assumes increment and clear are single-cycle strobes on the same clock.
`timescale 1ns/100ps
module sat_counter
  import cmd_diag_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             inc_i,
  input  wire logic             clr_i,
  output logic [WIDTH-1:0]      count_o
);

  logic [WIDTH-1:0] count_q;

  // Count up, stick at all ones, an event in the clear cycle survives
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      count_q <= '0;
    end else if (clr_i) begin
      count_q <= inc_i ? WIDTH'(1) : '0;
    end else if (inc_i && (count_q != {WIDTH{1'b1}})) begin
      count_q <= count_q + WIDTH'(1);
    end
  end

  assign count_o = count_q;

endmodule

// file: include/cmd_diag_pkg.sv
// Shared constants, command codes and carriers for the command-mode block.
// Assumes a 20 MHz module clock and a byte-wide serial front end on the same clock.
package cmd_diag_pkg;

  // Clock and time units
  localparam int unsigned CLOCK_HZ        = 20000000;
  localparam int unsigned MS_TICK_US      = 1000;                  // Guard time unit, us
  localparam int unsigned MS_TICK_CYCLES  = CLOCK_HZ / 1000000 * MS_TICK_US;
  localparam int unsigned TIMEOUT_UNIT_MS = 100;                   // Command timeout unit
  localparam int unsigned SCAN_UNIT_NS    = 15360000;              // 15.36 ms dwell base
  localparam int unsigned SCAN_UNIT_CYCLES = SCAN_UNIT_NS / (1000000000 / CLOCK_HZ);

  // Parameter widths
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned EXP_W  = 3;

  // Reset values and legal ranges
  localparam logic [15:0] TIMEOUT_RESET = 16'h0064;
  localparam logic [15:0] TIMEOUT_MIN   = 16'h0002;
  localparam logic [15:0] GUARD_RESET   = 16'h03e8;
  localparam logic [15:0] GUARD_MIN     = 16'h0002;
  localparam logic [15:0] GUARD_MAX     = 16'h0ce4;
  localparam logic [7:0]  ESC_RESET     = 8'h2b;
  localparam logic [2:0]  EXP_RESET     = 3'h0;
  localparam logic [2:0]  EXP_MAX       = 3'h6;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  localparam logic [7:0]  CR_BYTE       = 8'h0d;
  localparam logic [1:0]  ESC_COUNT     = 2'h3;

  // Parameter and command codes of the command port
  typedef enum logic [3:0] {
    CMD_FIRMWARE_VERSION = 4'h0,
    CMD_HARDWARE_VERSION = 4'h1,
    CMD_RSSI_LEVEL       = 4'h2,
    CMD_CHANNEL_BUSY     = 4'h3,
    CMD_RETRY_EXHAUST    = 4'h4,
    CMD_COMMAND_TIMEOUT  = 4'h5,
    CMD_GUARD_TIME       = 4'h6,
    CMD_ESCAPE_CHAR      = 4'h7,
    CMD_SCAN_EXPONENT    = 4'h8,
    CMD_ENERGY_SCAN      = 4'h9,
    CMD_LEAVE            = 4'ha,
    CMD_APPLY            = 4'hb
  } cmd_code_e;

  // One parsed command from the host
  typedef struct packed {
    cmd_code_e         code;
    logic              write;
    logic [WORD_W-1:0] wdata;
  } cmd_req_s;

  // Answer to one command
  typedef struct packed {
    logic              err;
    logic [WORD_W-1:0] rdata;
  } cmd_rsp_s;

  // Parameter set that governs operation
  typedef struct packed {
    logic [WORD_W-1:0] timeout;
    logic [WORD_W-1:0] guard;
    logic [BYTE_W-1:0] esc;
    logic [EXP_W-1:0]  exponent;
  } param_set_s;

  localparam param_set_s PARAM_RESET = '{timeout: TIMEOUT_RESET, guard: GUARD_RESET,
                                         esc: ESC_RESET, exponent: EXP_RESET};

endpackage

// file: test/command_mode_diagnostics_assertions.sv
// Port checker for the command-mode block.
// Assumes it is bound onto every instance of the block.
`timescale 1ns/100ps
module command_mode_diagnostics_assertions
  import cmd_diag_pkg::*;
#(
  parameter int unsigned MS_CYCLES      = MS_TICK_CYCLES,
  parameter logic [15:0] FIRMWARE_VALUE = 16'h0000
) (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       data_valid_o,
  input  wire logic [7:0] data_byte_o,
  input  wire logic       command_mode_o,
  input  wire logic       cmd_valid_i,
  input  wire cmd_req_s   cmd_req_i,
  input  wire logic       rsp_valid_o,
  input  wire cmd_rsp_s   rsp_o,
  input  wire logic       reinit_o,
  input  wire param_set_s params_o,
  input  wire logic       tx_valid_o,
  input  wire logic [7:0] tx_byte_o,
  input  wire logic       tx_ready_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic        take;
  logic [31:0] quiet_q;
  logic [31:0] idle_q;
  // Command accepted this cycle
  assign take = cmd_valid_i && command_mode_o;
  // Cycles since the last received byte
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || rx_valid_i) begin
      quiet_q <= '0;
    end else if (quiet_q != '1) begin
      quiet_q <= quiet_q + 32'h1;
    end
  end
  // Cycles in command mode without an accepted command
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !command_mode_o || take) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + 32'h1;
    end
  end
  property p_leave;
    take && cmd_req_i.code == CMD_LEAVE |=> !command_mode_o;
  endproperty
  a_leave: assert property (p_leave) else $error("mode kept after leave");
  property p_reinit;
    take && cmd_req_i.code inside {CMD_APPLY, CMD_LEAVE} |=> reinit_o && rsp_valid_o;
  endproperty
  a_reinit: assert property (p_reinit) else $error("no reinit pulse");
  property p_fw;
    take && !cmd_req_i.write && cmd_req_i.code == CMD_FIRMWARE_VERSION
      |=> rsp_valid_o && !rsp_o.err && rsp_o.rdata == FIRMWARE_VALUE;
  endproperty
  a_fw: assert property (p_fw) else $error("firmware value wrong");
  property p_ro;
    take && cmd_req_i.write
      && cmd_req_i.code inside {CMD_FIRMWARE_VERSION, CMD_HARDWARE_VERSION, CMD_RSSI_LEVEL}
      |=> rsp_valid_o && rsp_o.err;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write taken");
  property p_cnt;
    take && cmd_req_i.write && cmd_req_i.wdata != 16'h0000
      && cmd_req_i.code inside {CMD_CHANNEL_BUSY, CMD_RETRY_EXHAUST} |=> rsp_o.err;
  endproperty
  a_cnt: assert property (p_cnt) else $error("nonzero counter write taken");
  property p_fwd;
    rx_valid_i && !command_mode_o |=> data_valid_o && data_byte_o == $past(rx_byte_i);
  endproperty
  a_fwd: assert property (p_fwd) else $error("data byte not forwarded");
  property p_guard;
    $rose(command_mode_o) |-> quiet_q + 32'd2 >= params_o.guard * MS_CYCLES;
  endproperty
  a_guard: assert property (p_guard) else $error("entry before guard");
  property p_timeout;
    command_mode_o |-> idle_q <= params_o.timeout * 100 * MS_CYCLES + MS_CYCLES + 2;
  endproperty
  a_timeout: assert property (p_timeout) else $error("mode outlived timeout");
  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o);
  endproperty
  a_hold: assert property (p_hold) else $error("scan byte dropped");
  c_enter: cover property ($rose(command_mode_o));
  c_apply: cover property (take && cmd_req_i.code == CMD_APPLY);
  c_cr: cover property (tx_valid_o && tx_ready_i && tx_byte_o == CR_BYTE);
endmodule
bind command_mode_diagnostics command_mode_diagnostics_assertions #(
  .MS_CYCLES(MS_CYCLES), .FIRMWARE_VALUE(FIRMWARE_VALUE)
) chk_u (.clock_i, .rst_b_i, .rx_valid_i, .rx_byte_i, .data_valid_o, .data_byte_o,
  .command_mode_o, .cmd_valid_i, .cmd_req_i, .rsp_valid_o, .rsp_o, .reinit_o,
  .params_o, .tx_valid_o, .tx_byte_o, .tx_ready_i);

// file: test/command_mode_diagnostics_tb_top.sv
// Self-checking bench for the command-mode block.
// Assumes the host model and shortened time-unit parameters.
`timescale 1ns/100ps
module command_mode_diagnostics_tb_top;
  import cmd_diag_pkg::*;
  localparam int MS = 10;
  localparam int SC = 8;
  localparam int CH = 2;
  localparam logic [15:0] FW = 16'h0a51; // Arbitrary value
  localparam logic [15:0] HW = 16'h0b72; // Arbitrary value
  logic       clock_i = 1'b0, rst_b_i = 1'b0, ph = 1'b0;
  logic       rx_valid_i, data_valid_o, command_mode_o, rsp_valid_o, reinit_o;
  logic [7:0] rx_byte_i, data_byte_o, scan_channel_o, tx_byte_o;
  logic       cmd_valid_i = 1'b0, cca_fail_i = 1'b0, retry_exhaust_i = 1'b0;
  logic       rssi_update_i = 1'b0, tx_ready_i = 1'b0, scan_busy_o, tx_valid_o;
  logic [7:0] rssi_i = 8'h00, energy_i = 8'h00;
  cmd_req_s   cmd_req_i = '0;
  cmd_rsp_s   rsp_o;
  param_set_s params_o;
  int         miscompares = 0, total_checks = 0, fwd_n = 0;

  always #25 clock_i = ~clock_i;
  host_model host_u (.clock_i, .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));
  command_mode_diagnostics #(.MS_CYCLES(MS), .SCAN_CYCLES(SC), .CHANNELS(CH),
    .FIRMWARE_VALUE(FW), .HARDWARE_VALUE(HW)) dut_u (.clock_i, .rst_b_i,
    .rx_valid_i, .rx_byte_i, .data_valid_o, .data_byte_o, .command_mode_o,
    .cmd_valid_i, .cmd_req_i, .rsp_valid_o, .rsp_o, .reinit_o, .params_o,
    .cca_fail_i, .retry_exhaust_i, .rssi_update_i, .rssi_i, .energy_i,
    .scan_channel_o, .scan_busy_o, .tx_valid_o, .tx_byte_o, .tx_ready_i);
  // Energy alternates between noise and a per-channel peak
  always @(posedge clock_i) begin
    ph       <= ~ph;
    energy_i <= ph ? 8'h50 : 8'h40 - scan_channel_o;
    if (data_valid_o) fwd_n++;
  end

  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic cmd(input cmd_code_e c, input logic w, input logic [15:0] d);
    @(posedge clock_i);
    cmd_valid_i <= 1'b1;
    cmd_req_i   <= '{code: c, write: w, wdata: d};
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    @(negedge clock_i);
  endtask
  task automatic cx(input cmd_code_e c, input logic w, input logic [15:0] d, input logic e);
    cmd(c, w, d);
    chk("rsp_valid", 1, rsp_valid_o);
    chk("rsp_err", e, rsp_o.err);
  endtask
  task automatic rd(input cmd_code_e c, input logic [15:0] v);
    cx(c, 1'b0, 16'h0000, 1'b0);
    chk("rsp_rdata", v, rsp_o.rdata);
  endtask
  task automatic accept;
    @(posedge clock_i);
    tx_ready_i <= 1'b1;
    @(posedge clock_i);
    tx_ready_i <= 1'b0;
    @(negedge clock_i);
  endtask
  task automatic enter(input logic [7:0] ch, input int g);
    int n0, k;
    n0 = fwd_n;
    host_u.escape(ch, g * MS + 2 * MS, 3);
    idle((g - 1) * MS);
    chk("mode_early", 0, command_mode_o);
    k = 0;
    while (command_mode_o !== 1'b1 && k < 4 * MS) begin
      idle(1);
      k++;
    end
    chk("mode_on", 1, command_mode_o);
    chk("fwd_count", n0 + 3, fwd_n);
  endtask
  task automatic t_diag;
    rd(CMD_FIRMWARE_VERSION, FW);
    rd(CMD_HARDWARE_VERSION, HW);
    cx(CMD_FIRMWARE_VERSION, 1, 16'h0000, 1);
    cx(CMD_HARDWARE_VERSION, 1, 16'hffff, 1);
    rd(CMD_HARDWARE_VERSION, HW);
    @(posedge clock_i);
    rssi_update_i <= 1'b1;
    rssi_i        <= 8'h58;
    @(posedge clock_i);
    rssi_update_i <= 1'b0;
    rssi_i        <= 8'h17;
    rd(CMD_RSSI_LEVEL, 16'h0058);
    cx(CMD_RSSI_LEVEL, 1, 16'h0010, 1);
    cx(cmd_code_e'(4'hc), 1, 16'h0000, 1);
  endtask
  task automatic t_count;
    cx(CMD_CHANNEL_BUSY, 1, 16'h0001, 1);
    cx(CMD_RETRY_EXHAUST, 1, 16'h0002, 1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_i);
      cca_fail_i      <= 1'b1;
      retry_exhaust_i <= (i < 2);
      @(posedge clock_i);
      cca_fail_i      <= 1'b0;
      retry_exhaust_i <= 1'b0;
    end
    rd(CMD_CHANNEL_BUSY, 16'h0003);
    rd(CMD_RETRY_EXHAUST, 16'h0002);
    @(posedge clock_i);
    cca_fail_i      <= 1'b1;
    retry_exhaust_i <= 1'b1;
    repeat (65540) @(posedge clock_i);
    cca_fail_i      <= 1'b0;
    retry_exhaust_i <= 1'b0;
    rd(CMD_CHANNEL_BUSY, COUNT_MAX);
    rd(CMD_RETRY_EXHAUST, COUNT_MAX);
    cx(CMD_CHANNEL_BUSY, 1, 16'h0000, 0);
    cx(CMD_RETRY_EXHAUST, 1, 16'h0000, 0);
    rd(CMD_CHANNEL_BUSY, 16'h0000);
    rd(CMD_RETRY_EXHAUST, 16'h0000);
  endtask
  task automatic t_config;
    cx(CMD_COMMAND_TIMEOUT, 1, 16'h0001, 1);
    cx(CMD_GUARD_TIME, 1, 16'h0001, 1);
    cx(CMD_GUARD_TIME, 1, 16'h0ce5, 1);
    cx(CMD_SCAN_EXPONENT, 1, 16'h0007, 1);
    cx(CMD_GUARD_TIME, 1, GUARD_MAX, 0);
    cx(CMD_COMMAND_TIMEOUT, 1, 16'h0002, 0);
    cx(CMD_GUARD_TIME, 1, 16'h0002, 0);
    cx(CMD_SCAN_EXPONENT, 1, 16'h0001, 0);
    rd(CMD_GUARD_TIME, 16'h0002);
    rd(CMD_COMMAND_TIMEOUT, 16'h0002);
    rd(CMD_SCAN_EXPONENT, 16'h0001);
    chk("params_queued", PARAM_RESET, params_o);
    cx(CMD_APPLY, 0, 16'h0000, 0);
    chk("reinit", 1, reinit_o);
    chk("params_applied", param_set_s'{16'h2, 16'h2, 8'h2b, 3'h1}, params_o);
  endtask
  task automatic t_scan;
    int n;
    cx(CMD_ENERGY_SCAN, 0, 16'h0000, 0);
    cx(CMD_ENERGY_SCAN, 0, 16'h0000, 1);
    for (int k = 0; k < CH; k++) begin
      n = 0;
      while (tx_valid_o !== 1'b1 && n < 100) begin
        idle(1);
        n++;
      end
      chk("dwell_ok", 1, n >= SC * 2 - 6 && n <= SC * 2 + 4);
      chk("channel", k, scan_channel_o);
      idle(2);
      chk("peak", 8'h40 - k, tx_byte_o);
      accept;
      n = 0;
      while (tx_valid_o !== 1'b1 && n < 10) begin
        idle(1);
        n++;
      end
      chk("cr", CR_BYTE, tx_byte_o);
      accept;
    end
    idle(3);
    chk("scan_done", 0, scan_busy_o);
  endtask
  task automatic t_leave;
    cx(CMD_ESCAPE_CHAR, 1, 16'h0100, 1);
    cx(CMD_ESCAPE_CHAR, 1, 16'h002a, 0);
    rd(CMD_ESCAPE_CHAR, 16'h002a);
    cx(CMD_LEAVE, 0, 16'h0000, 0);
    chk("mode_off", 0, command_mode_o);
    chk("esc_applied", 8'h2a, params_o.esc);
    cmd(CMD_FIRMWARE_VERSION, 0, 16'h0000);
    chk("ignored", 0, rsp_valid_o);
  endtask
  task automatic t_cancel;
    host_u.escape(8'h2a, 40, 2);
    host_u.send(8'h41);
    idle(60);
    chk("cancel_other", 0, command_mode_o);
    host_u.escape(8'h2a, 40, 4);
    idle(60);
    chk("cancel_four", 0, command_mode_o);
    host_u.escape(8'h2b, 40, 3);
    idle(60);
    chk("old_char", 0, command_mode_o);
  endtask
  task automatic t_timeout;
    int n;
    idle(2 * 100 * MS - 2 * MS);
    chk("mode_held", 1, command_mode_o);
    n = 0;
    while (command_mode_o !== 1'b0 && n < 5 * MS) begin
      idle(1);
      n++;
    end
    chk("timed_out", 0, command_mode_o);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    idle(1);
    chk("reset_params", PARAM_RESET, params_o);
    chk("reset_mode", 0, command_mode_o);
    enter(ESC_RESET, 1000);
    t_diag;
    t_count;
    t_config;
    t_scan;
    t_leave;
    t_cancel;
    enter(8'h2a, 2);
    t_timeout;
    stop_test;
  end
  // Watchdog
  initial begin
    repeat (97000) @(posedge clock_i);
    miscompares++;
    stop_test;
  end
endmodule

// file: test/host_model.sv
// Host model: serial bytes and the guarded entry sequence.
// Assumes the block samples bytes on the rising clock edge.
`timescale 1ns/100ps
module host_model (
  input  wire logic  clock_i,
  output logic       rx_valid_o,
  output logic [7:0] rx_byte_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
  end
  // One byte for one cycle, then junk on the line
  task automatic send(input logic [7:0] b);
    @(posedge clock_i);
    rx_valid_o <= 1'b1;
    rx_byte_o  <= b;
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_byte_o  <= ~b;
  endtask
  task automatic escape(input logic [7:0] ch, input int gap, input int n);
    repeat (gap) @(posedge clock_i);
    repeat (n) send(ch);
  endtask
endmodule
